// ### rtl/pcc_params.svh
// Constants of the preset count controller: timing, limits and register offsets.
// Assumes a 200 MHz system clock and a 5-bit register address.
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define PCC_CLK_HZ          200000000
`define PCC_CLK_KHZ         200000
`define PCC_RATE_LO_CPS     30
`define PCC_RATE_HI_CPS     5000
`define PCC_PULSE_LONG_MS   500
`define PCC_PULSE_SHORT_MS  50
`define PCC_RST_LONG_MS     20
`define PCC_RST_SHORT_MS    1

// ****************************************************************
// Count limits and reset values
// ****************************************************************
`define PCC_PV_MIN          16'hfc19
`define PCC_PV_MAX          16'h270f
`define PCC_CFG_RESET       6'h00
`define PCC_IEN_RESET       3'h0

// ****************************************************************
// Register offsets and interrupt bit positions
// ****************************************************************
`define PCC_OFS_STATUS      5'h00
`define PCC_OFS_CLEAR       5'h04
`define PCC_OFS_ENABLE      5'h08
`define PCC_OFS_PV          5'h0c
`define PCC_OFS_SV          5'h10
`define PCC_OFS_CFG         5'h14
`define PCC_IRQ_REACH       0
`define PCC_IRQ_UNDER       1
`define PCC_IRQ_RESET       2

`endif

// ### rtl/pcc_pkg.sv
// Types shared by the preset count controller.
// Assumes the constants header is used beside it for every number.
package pcc_pkg;

  typedef enum logic [1:0] {
    PCC_HOLD_STOP      = 2'b00,
    PCC_OVERCOUNT_HOLD = 2'b01,
    PCC_AUTO_RELOAD    = 2'b10,
    PCC_OVERRUN_PULSE  = 2'b11
  } pcc_mode_e;

  typedef enum logic [1:0] {
    PCC_OUT_OFF   = 2'b00,
    PCC_OUT_LATCH = 2'b01,
    PCC_OUT_PULSE = 2'b10
  } pcc_out_e;

  // Bit order follows the six switches, switch 1 in the lowest bit.
  typedef struct packed {
    logic      rst_short;
    logic      pulse_short;
    pcc_mode_e mode;
    logic      count_down;
    logic      rate_hi;
  } pcc_cfg_s;

  typedef struct packed {
    logic       clear;
    logic       protect;
    logic [3:0] up;
    logic [3:0] down;
  } pcc_keys_s;

endpackage

// ### rtl/pcc_top.sv
// Preset count controller: filtered counting, four output modes, set-value keys.
// Assumes raw pin inputs, a 200 MHz sys_clk and a one-cycle register port master.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pcc_params.svh"

module pcc_top #(
  parameter int unsigned FILT_LO_CYC    = `PCC_CLK_HZ / (4 * `PCC_RATE_LO_CPS),
  parameter int unsigned FILT_HI_CYC    = `PCC_CLK_HZ / (4 * `PCC_RATE_HI_CPS),
  parameter int unsigned PULSE_LONG_CYC = `PCC_CLK_KHZ * `PCC_PULSE_LONG_MS,
  parameter int unsigned PULSE_SHRT_CYC = `PCC_CLK_KHZ * `PCC_PULSE_SHORT_MS,
  parameter int unsigned RST_LONG_CYC   = `PCC_CLK_KHZ * `PCC_RST_LONG_MS,
  parameter int unsigned RST_SHRT_CYC   = `PCC_CLK_KHZ * `PCC_RST_SHORT_MS
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              count_in,
  input  wire logic              reset_in,
  input  wire pcc_pkg::pcc_keys_s keys_in,
  input  wire logic [5:0]        cfg_sw,
  input  wire logic [4:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   ctrl_out,
  output logic                   ctrl_ind,
  output logic                   reset_ind,
  output logic                   key_prot_ind,
  output logic                   underflow_err,
  output logic                   irq,
  output logic [15:0]            present_value,
  output logic [15:0]            set_value_bcd
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [17:0]         sync1_ff;
  logic [17:0]         sync2_ff;
  logic [9:0]          key_q_ff;
  wire  [17:0]         pin_raw = {cfg_sw, keys_in, reset_in, count_in};
  wire                 cnt_s   = sync2_ff[0];
  wire                 rst_s   = sync2_ff[1];
  wire pcc_pkg::pcc_keys_s keys_s = pcc_pkg::pcc_keys_s'(sync2_ff[11:2]);
  wire pcc_pkg::pcc_keys_s key_rise = pcc_pkg::pcc_keys_s'(sync2_ff[11:2] & ~key_q_ff);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= 18'h00000;
      sync2_ff <= 18'h00000;
      key_q_ff <= 10'h000;
    end
    else
    begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      key_q_ff <= sync2_ff[11:2];
    end
  end

  // ****************************************************************
  // Switch capture after power-up
  // ****************************************************************
  pcc_pkg::pcc_cfg_s   cfg_ff;
  logic [1:0]          cfg_wait_ff;
  logic                cfg_done_ff;
  // The synchroniser needs two edges after release before the switches are valid.
  wire                 cfg_load = (cfg_wait_ff == 2'h2);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_ff      <= pcc_pkg::pcc_cfg_s'(`PCC_CFG_RESET);
      cfg_wait_ff <= 2'h0;
      cfg_done_ff <= 1'b0;
    end
    else
    begin
      if (cfg_wait_ff != 2'h3)
        cfg_wait_ff <= cfg_wait_ff + 2'h1;
      if (cfg_load)
        cfg_ff <= pcc_pkg::pcc_cfg_s'(sync2_ff[17:12]);
      cfg_done_ff <= cfg_done_ff || cfg_load;
    end
  end

  wire                 pulse_mode = cfg_ff.mode[1];
  wire                 hold_stop  = (cfg_ff.mode == pcc_pkg::PCC_HOLD_STOP);
  wire                 auto_mode  = (cfg_ff.mode == pcc_pkg::PCC_AUTO_RELOAD);
  wire                 protect    = keys_s.protect;

  // ****************************************************************
  // Count input filter
  // ****************************************************************
  logic [31:0]         filt_cnt_ff;
  logic                filt_lvl_ff;
  wire  [31:0]         filt_len  = cfg_ff.rate_hi ? FILT_HI_CYC : FILT_LO_CYC;
  wire  [31:0]         filt_inc  = filt_cnt_ff + 32'h00000001;
  wire                 filt_flip = (cnt_s != filt_lvl_ff) && (filt_inc >= filt_len);
  wire                 cnt_rise  = filt_flip && cnt_s;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      filt_cnt_ff <= 32'h00000000;
      filt_lvl_ff <= 1'b0;
    end
    else
    begin
      filt_cnt_ff <= (cnt_s != filt_lvl_ff && !filt_flip) ? filt_inc : 32'h00000000;
      if (filt_flip)
        filt_lvl_ff <= cnt_s;
    end
  end

  // ****************************************************************
  // Reset input width qualifier
  // ****************************************************************
  logic [31:0]         rst_cnt_ff;
  logic                rst_hold_ff;
  wire  [31:0]         rst_len  = cfg_ff.rst_short ? RST_SHRT_CYC : RST_LONG_CYC;
  wire                 rst_take = rst_s && !rst_hold_ff && (rst_cnt_ff + 32'h00000001 >= rst_len);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_cnt_ff  <= 32'h00000000;
      rst_hold_ff <= 1'b0;
    end
    else
    begin
      rst_cnt_ff  <= (rst_s && !rst_hold_ff) ? rst_cnt_ff + 32'h00000001 : 32'h00000000;
      rst_hold_ff <= rst_s && (rst_hold_ff || rst_take);
    end
  end

  wire                 clr_evt = key_rise.clear && !protect;
  wire                 reinit  = clr_evt || rst_hold_ff || cfg_load;

  // ****************************************************************
  // Set value digits
  // ****************************************************************
  logic [3:0]          sv_dig_ff [4];
  genvar               gd;
  generate
    for (gd = 0; gd < 4; gd++)
    begin : g_digit
      wire up_evt = key_rise.up[gd] && !protect;
      wire dn_evt = key_rise.down[gd] && !protect;
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
          sv_dig_ff[gd] <= 4'h0;
        else if (up_evt)
          sv_dig_ff[gd] <= (sv_dig_ff[gd] == 4'h9) ? 4'h0 : sv_dig_ff[gd] + 4'h1;
        else if (dn_evt)
          sv_dig_ff[gd] <= (sv_dig_ff[gd] == 4'h0) ? 4'h9 : sv_dig_ff[gd] - 4'h1;
      end
    end
  endgenerate

  wire  [15:0]         sv_bin = {12'h000, sv_dig_ff[0]} + 16'({12'h000, sv_dig_ff[1]} * 16'h000a)
                              + 16'({12'h000, sv_dig_ff[2]} * 16'h0064)
                              + 16'({12'h000, sv_dig_ff[3]} * 16'h03e8);

  // ****************************************************************
  // Present value
  // ****************************************************************
  logic [15:0]         pv_ff;
  logic                uf_ff;
  logic                match_q_ff;
  pcc_pkg::pcc_out_e   out_ff;
  pcc_pkg::pcc_out_e   nxt_out;
  logic [31:0]         tmr_ff;
  logic [31:0]         nxt_tmr;

  wire  [15:0]         target   = cfg_ff.count_down ? 16'h0000 : sv_bin;
  wire  [15:0]         init_val = cfg_ff.count_down ? sv_bin : 16'h0000;
  wire                 match    = (pv_ff == target);
  wire                 frozen   = hold_stop && (match || out_ff == pcc_pkg::PCC_OUT_LATCH);
  wire                 cnt_step = cnt_rise && cfg_done_ff && !rst_hold_ff && !frozen;
  wire  [15:0]         step_val = cfg_ff.count_down ? pv_ff - 16'h0001 : pv_ff + 16'h0001;
  wire                 at_lim   = cfg_ff.count_down ? (pv_ff == `PCC_PV_MIN)
                                                    : (pv_ff == `PCC_PV_MAX);
  wire                 uf_evt   = cnt_step && at_lim && cfg_ff.count_down;
  wire                 auto_hit = cnt_step && auto_mode && (step_val == target);
  wire                 hit      = auto_hit || (match && !match_q_ff);
  wire  [15:0]         nxt_pv   = reinit || auto_hit ? init_val
                                : (cnt_step && !at_lim) ? step_val : pv_ff;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pv_ff      <= 16'h0000;
      uf_ff      <= 1'b0;
      match_q_ff <= 1'b0;
    end
    else
    begin
      pv_ff      <= nxt_pv;
      uf_ff      <= (uf_ff && !(clr_evt || rst_hold_ff)) || uf_evt;
      // forcing the edge makes a zero set value fire on release.
      match_q_ff <= match && !reinit;
    end
  end

  // ****************************************************************
  // Control output state machine
  // ****************************************************************
  // pulse length
  wire  [31:0]         pulse_len = cfg_ff.pulse_short ? PULSE_SHRT_CYC : PULSE_LONG_CYC;

  always_comb
  begin
    nxt_out = out_ff;
    nxt_tmr = tmr_ff;
    if (reinit)
    begin
      nxt_out = pcc_pkg::PCC_OUT_OFF;
      nxt_tmr = 32'h00000000;
    end
    else
    begin
      case (out_ff)
        pcc_pkg::PCC_OUT_OFF:
        begin
          if (!pulse_mode && match)
            nxt_out = pcc_pkg::PCC_OUT_LATCH;
          else if (pulse_mode && hit)
          begin
            nxt_out = pcc_pkg::PCC_OUT_PULSE;
            nxt_tmr = pulse_len;
          end
        end
        pcc_pkg::PCC_OUT_LATCH:
          nxt_out = pcc_pkg::PCC_OUT_LATCH;
        pcc_pkg::PCC_OUT_PULSE:
        begin
          if (hit)
            nxt_tmr = pulse_len;
          else if (tmr_ff <= 32'h00000001)
          begin
            nxt_out = pcc_pkg::PCC_OUT_OFF;
            nxt_tmr = 32'h00000000;
          end
          else
            nxt_tmr = tmr_ff - 32'h00000001;
        end
        default:
        begin
          nxt_out = pcc_pkg::PCC_OUT_OFF;
          nxt_tmr = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_ff <= pcc_pkg::PCC_OUT_OFF;
      tmr_ff <= 32'h00000000;
    end
    else
    begin
      out_ff <= nxt_out;
      tmr_ff <= nxt_tmr;
    end
  end

  // ****************************************************************
  // Interrupts and register port
  // ****************************************************************
  logic [2:0]          ist_ff;
  logic [2:0]          ien_ff;
  logic [31:0]         rdata_ff;
  logic                prot_ff;
  wire                 reach_evt = (out_ff == pcc_pkg::PCC_OUT_OFF)
                                && (nxt_out != pcc_pkg::PCC_OUT_OFF);
  wire  [2:0]          ev_vec    = {rst_take, uf_evt, reach_evt};
  wire                 wr_clr    = reg_wr && (reg_addr == `PCC_OFS_CLEAR);
  wire                 wr_en     = reg_wr && (reg_addr == `PCC_OFS_ENABLE);
  wire  [31:0]         rd_mux    =
      (reg_addr == `PCC_OFS_STATUS) ? {29'h0, ist_ff} :
      (reg_addr == `PCC_OFS_ENABLE) ? {29'h0, ien_ff} :
      (reg_addr == `PCC_OFS_PV)     ? {16'h0000, pv_ff} :
      (reg_addr == `PCC_OFS_SV)     ? {16'h0000, set_value_bcd} :
      (reg_addr == `PCC_OFS_CFG)    ? {24'h000000, cfg_done_ff, uf_ff, 6'(cfg_ff)} :
                                      32'h00000000;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ist_ff   <= 3'h0;
      ien_ff   <= `PCC_IEN_RESET;
      rdata_ff <= 32'h00000000;
      prot_ff  <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle.
      ist_ff   <= (ist_ff & ~(wr_clr ? reg_wdata[2:0] : 3'h0)) | ev_vec;
      if (wr_en)
        ien_ff <= reg_wdata[2:0];
      rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
      prot_ff  <= protect;
    end
  end

  assign reg_rdata     = rdata_ff;
  assign ctrl_out      = (out_ff != pcc_pkg::PCC_OUT_OFF);
  assign ctrl_ind      = ctrl_out;
  assign reset_ind     = rst_hold_ff;
  assign key_prot_ind  = prot_ff;
  assign underflow_err = uf_ff;
  assign irq           = |(ist_ff & ien_ff);
  assign present_value = pv_ff;
  assign set_value_bcd = {sv_dig_ff[3], sv_dig_ff[2], sv_dig_ff[1], sv_dig_ff[0]};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_hold_freeze: assert property (hold_stop && out_ff == pcc_pkg::PCC_OUT_LATCH && !reinit
      |=> pv_ff == $past(pv_ff) && ctrl_out) else $error("hold stop value moved");
  a_latch_keeps: assert property (!pulse_mode && ctrl_out && !reinit |=> ctrl_out)
      else $error("latched output dropped");
  a_reload_pv: assert property (auto_hit && !reinit |=> pv_ff == $past(init_val) && ctrl_out)
      else $error("auto reload missed");
  a_pulse_timer: assert property (out_ff == pcc_pkg::PCC_OUT_PULSE |-> tmr_ff <= pulse_len)
      else $error("pulse timer exceeds length");
  a_no_pulse: assert property (!pulse_mode |-> out_ff != pcc_pkg::PCC_OUT_PULSE)
      else $error("pulse in hold mode");
  a_cfg_frozen: assert property (cfg_done_ff |=> $stable(cfg_ff))
      else $error("switches changed after capture");
  a_reset_off: assert property (reinit |=> !ctrl_out)
      else $error("output on after reinit");
  a_up_step: assert property (cnt_step && !cfg_ff.count_down && !at_lim && !auto_hit
      && !reinit |=> pv_ff == $past(pv_ff) + 16'h0001) else $error("up count wrong");
  a_uf_sticky: assert property (uf_ff && !clr_evt && !rst_hold_ff |=> uf_ff)
      else $error("underflow flag lost");
  a_match_on: assert property (!pulse_mode && match && !reinit |=> ctrl_out)
      else $error("match did not drive output");
  a_prot_keys: assert property (protect |=> $stable(set_value_bcd))
      else $error("set value changed while protected");
  c_pulse: cover property (out_ff == pcc_pkg::PCC_OUT_PULSE ##1 out_ff == pcc_pkg::PCC_OUT_OFF);
  c_latch: cover property (out_ff == pcc_pkg::PCC_OUT_LATCH);
  c_under: cover property ($rose(uf_ff));
  c_reset: cover property (rst_take);
endmodule

// ### tb/pcc_field_model.sv
// Far side of the preset count controller: pulse sensor, reset switch and keys.
// Assumes the bench calls its tasks and that sys_clk is the controller's clock.
`timescale 1ns/1ps

module pcc_field_model (
  input  wire logic               sys_clk,
  output pcc_pkg::pcc_keys_s      keys,
  output logic                    count_in,
  output logic                    reset_in
);
  initial
  begin
    keys     = '0;
    count_in = 1'b0;
    reset_in = 1'b0;
  end

  // ****************************************************************
  // Sensor and switch stimulus
  // ****************************************************************
  // every half period lasts w clock cycles.
  task automatic pulses(input int n, input int w);
    repeat (n)
    begin
      @(posedge sys_clk) count_in <= 1'b1;
      repeat (w) @(posedge sys_clk);
      count_in <= 1'b0;
      repeat (w - 1) @(posedge sys_clk);
    end
  endtask

  task automatic rst(input int n);
    @(posedge sys_clk) reset_in <= 1'b1;
    repeat (n) @(posedge sys_clk);
    reset_in <= 1'b0;
  endtask

  task automatic set_key(input int idx, input logic v);
    @(posedge sys_clk) keys[idx] <= v;
  endtask

  // A press is held long enough to pass the key synchroniser.
  task automatic press(input int idx);
    set_key(idx, 1'b1);
    repeat (6) @(posedge sys_clk);
    keys[idx] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench of the preset count controller, one task per scenario.
// Assumes the shortened timing parameters below and the field model beside it.
`timescale 1ns/1ps
`include "pcc_params.svh"

module tb;
  logic               sys_clk;
  logic               nrst;
  logic [5:0]         cfg_sw;
  logic [4:0]         reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  logic               ctrl_out;
  logic               ctrl_ind;
  logic               reset_ind;
  logic               key_prot_ind;
  logic               underflow_err;
  logic               irq;
  logic [15:0]        present_value;
  logic [15:0]        set_value_bcd;
  logic               count_in;
  logic               reset_in;
  pcc_pkg::pcc_keys_s keys;
  int                 failures = 0;
  int                 checked = 0;
  logic [31:0]        rd;
  int                 wid;
  logic               c0;

  pcc_field_model fm (.sys_clk(sys_clk), .keys(keys), .count_in(count_in), .reset_in(reset_in));

  pcc_top #(.FILT_LO_CYC(8), .FILT_HI_CYC(2), .PULSE_LONG_CYC(40), .PULSE_SHRT_CYC(10),
            .RST_LONG_CYC(20), .RST_SHRT_CYC(4)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .count_in(count_in), .reset_in(reset_in),
    .keys_in(keys), .cfg_sw(cfg_sw), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_out(ctrl_out),
    .ctrl_ind(ctrl_ind), .reset_ind(reset_ind), .key_prot_ind(key_prot_ind),
    .underflow_err(underflow_err), .irq(irq), .present_value(present_value),
    .set_value_bcd(set_value_bcd));

  initial
  begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    cfg_sw = 6'h00;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  always #2.5 sys_clk = ~sys_clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Switches only load at power-up, so every scenario starts from a fresh reset.
  task automatic power_up(input logic [5:0] cfg);
    @(posedge sys_clk) nrst <= 1'b0;
    cfg_sw <= cfg;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk) reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk) reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic sv_three();
    repeat (3) fm.press(4);
  endtask

  // Counts the cycles of the next one-shot, bounded so a stuck output cannot hang.
  task automatic pulse_width(output int n);
    n = 0;
    for (int i = 0; i < 300 && !ctrl_out; i++) @(posedge sys_clk) #1;
    while (ctrl_out === 1'b1 && n < 200)
    begin
      n++;
      @(posedge sys_clk) #1;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    power_up(6'h00);
    reg_read(`PCC_OFS_CFG, rd);
    chk("cfg", 32'h80, rd);
    reg_read(5'h13, rd);
    chk("unmapped", 32'h0, rd);
    reg_read(`PCC_OFS_ENABLE, rd);
    chk("enable", 32'h0, rd);
    @(posedge sys_clk) cfg_sw <= 6'h3f;
    reg_read(`PCC_OFS_CFG, rd);
    chk("cfg_late", 32'h80, rd);
    $display("Test defaults done");
  endtask

  task automatic t_keys();
    power_up(6'h00);
    sv_three();
    chk("sv_up", 32'h3, {16'h0, set_value_bcd});
    fm.press(1);
    chk("sv_down", 32'h93, {16'h0, set_value_bcd});
    fm.press(5);
    fm.press(6);
    fm.press(7);
    chk("sv_up_hi", 32'h1103, {16'h0, set_value_bcd});
    fm.press(3);
    fm.press(2);
    fm.press(2);
    chk("sv_down_hi", 32'h0903, {16'h0, set_value_bcd});
    fm.set_key(8, 1'b1);
    repeat (5) @(posedge sys_clk);
    chk("prot_ind", 32'h1, {31'h0, key_prot_ind});
    fm.press(4);
    fm.press(9);
    chk("sv_prot", 32'h0903, {16'h0, set_value_bcd});
    chk("prot_clr", 32'h1, {31'h0, ctrl_out});
    fm.set_key(8, 1'b0);
    $display("Test keys done");
  endtask

  task automatic t_hold();
    power_up(6'h00);
    sv_three();
    // The zero set value latched the output at power-up; clear it before counting.
    fm.press(9);
    reg_write(`PCC_OFS_CLEAR, 32'h7);
    fm.pulses(1, 4);
    repeat (20) @(posedge sys_clk);
    chk("glitch", 32'h0, {16'h0, present_value});
    fm.pulses(2, 14);
    chk("pv2", 32'h2, {16'h0, present_value});
    chk("out_off", 32'h0, {31'h0, ctrl_out});
    fm.press(0);
    chk("out_sv_chg", 32'h1, {31'h0, ctrl_out});
    chk("ind_sv_chg", 32'h1, {31'h0, ctrl_ind});
    reg_read(`PCC_OFS_STATUS, rd);
    chk("st_reach", 32'h1, rd & 32'h1);
    reg_read(`PCC_OFS_PV, rd);
    chk("rd_pv", 32'h2, rd);
    reg_read(`PCC_OFS_SV, rd);
    chk("rd_sv", 32'h2, rd);
    reg_write(`PCC_OFS_ENABLE, 32'h1);
    chk("irq_on", 32'h1, {31'h0, irq});
    fm.pulses(2, 14);
    chk("pv_frozen", 32'h2, {16'h0, present_value});
    reg_write(`PCC_OFS_CLEAR, 32'h1);
    chk("irq_off", 32'h0, {31'h0, irq});
    fm.press(9);
    chk("clr_pv", 32'h0, {16'h0, present_value});
    chk("clr_out", 32'h0, {31'h0, ctrl_out});
    $display("Test hold done");
  endtask

  task automatic t_reset();
    power_up(6'h00);
    chk("zero_sv_out", 32'h1, {31'h0, ctrl_out});
    fm.rst(10);
    chk("short_rst", 32'h0, {31'h0, reset_ind});
    fm.rst(30);
    chk("rst_ind", 32'h1, {31'h0, reset_ind});
    chk("rst_out", 32'h0, {31'h0, ctrl_out});
    reg_read(`PCC_OFS_STATUS, rd);
    chk("st_rst", 32'h4, rd & 32'h4);
    repeat (6) @(posedge sys_clk);
    chk("rel_out", 32'h1, {31'h0, ctrl_out});
    power_up(6'h20);
    fm.rst(8);
    chk("rst_1ms", 32'h1, {31'h0, reset_ind});
    $display("Test reset done");
  endtask

  task automatic t_modes();
    power_up(6'h14);
    sv_three();
    fm.press(9);
    fm.pulses(5, 14);
    repeat (60) @(posedge sys_clk);
    chk("f_pv", 32'h5, {16'h0, present_value});
    chk("f_out", 32'h1, {31'h0, ctrl_out});
    power_up(6'h19);
    sv_three();
    repeat (50) @(posedge sys_clk);
    fork
      fm.pulses(3, 14);
      pulse_width(wid);
    join
    chk("c_width", 32'd10, wid);
    chk("c_reload", 32'h0, {16'h0, present_value});
    power_up(6'h0c);
    sv_three();
    repeat (50) @(posedge sys_clk);
    fork
      fm.pulses(4, 14);
      pulse_width(wid);
    join
    chk("k_width", 32'd40, wid);
    chk("k_pv", 32'h4, {16'h0, present_value});
    $display("Test modes done");
  endtask

  task automatic t_under();
    power_up(6'h07);
    reg_write(`PCC_OFS_ENABLE, 32'hfffffffa);
    c0 = ctrl_out;
    fm.pulses(1001, 5);
    repeat (10) @(posedge sys_clk);
    chk("u_pv", {16'h0, `PCC_PV_MIN}, {16'h0, present_value});
    chk("u_err", 32'h1, {31'h0, underflow_err});
    chk("u_out", {31'h0, c0}, {31'h0, ctrl_out});
    chk("u_irq", 32'h1, {31'h0, irq});
    fm.press(9);
    chk("u_clr", 32'h0, {31'h0, underflow_err});
    chk("u_pv0", 32'h0, {16'h0, present_value});
    $display("Test underflow done");
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    t_defaults();
    t_keys();
    t_hold();
    t_reset();
    t_modes();
    t_under();
    end_of_test();
  end

  initial
  begin
    #(5 * 60000);
    failures++;
    end_of_test();
  end
endmodule
